//--- design/fesr_pkg.sv
// constants shared by the feature error status register bank
package fesr_pkg;

	// ----------------------------------------------------------------
	// bus and register map
	// ----------------------------------------------------------------
	localparam int          FESR_ADDR_W     = 12;
	localparam int          FESR_DATA_W     = 32;
	localparam logic [11:0] FESR_OFS_UPPER  = 12'h640;
	localparam logic [11:0] FESR_OFS_LOWER  = 12'h644;
	localparam logic [11:0] FESR_OFS_ISTAT  = 12'h648;
	localparam logic [11:0] FESR_OFS_IMASK  = 12'h64c;
	localparam logic [1:0]  FESR_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  FESR_RESP_DECERR = 2'h3;
	localparam logic [31:0] FESR_WORD_RST   = 32'h0000_0000;

	// ----------------------------------------------------------------
	// features and flag positions
	// ----------------------------------------------------------------
	localparam int FESR_NFEAT   = 5;
	localparam int FESR_VAL_W   = 12;
	localparam int FESR_WORD_MSB = 31;

	typedef enum int {
		FESR_F_BRIGHT = 0,
		FESR_F_WBAL   = 1,
		FESR_F_SHUT   = 2,
		FESR_F_GAIN   = 3,
		FESR_F_TRIG   = 4
	} fesr_feat_t;

	// doc bit numbers, msb-first numbering
	localparam int FESR_DOC_BIT [FESR_NFEAT] = '{0, 3, 7, 8, 12};

endpackage

//--- design/fesr_range_chk.sv
// range check for one feature setting, refreshed on each write
module fesr_range_chk #(
	parameter int              W   = 12,
	parameter logic [W-1:0]    MIN = '0,
	parameter logic [W-1:0]    MAX = '1
) (
	input  wire logic          clk,     // system clock
	input  wire logic          nrst,    // async reset, active low
	input  wire logic          wr_stb,  // feature register written
	input  wire logic [W-1:0]  wr_val,  // value written
	output logic               err_q    // setting out of range
);

	// ----------------------------------------------------------------
	// flag
	// ----------------------------------------------------------------
	// refresh on write
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			err_q <= 1'b0;
		end else if (wr_stb) begin
			err_q <= (wr_val < MIN) || (wr_val > MAX);
		end
	end

endmodule

//--- design/fesr_top.sv
// feature error status register bank with axi4-lite slave and interrupt
//
// Local design decision: the AXI4-Lite slave port.
module fesr_top
	import fesr_pkg::*;
#(
	parameter logic [FESR_NFEAT*FESR_VAL_W-1:0] FEAT_MIN =
		{12'h000, 12'h000, 12'h001, 12'h000, 12'h000},
	parameter logic [FESR_NFEAT*FESR_VAL_W-1:0] FEAT_MAX =
		{12'h00f, 12'h3ff, 12'hfff, 12'h3ff, 12'h0ff},
	parameter bit                               COLOUR   = 1'b1
) (
	input  wire logic                           clk,          // system clock
	input  wire logic                           nrst,         // async reset
	input  wire logic [FESR_NFEAT-1:0]          feat_wr_stb,  // feature writes
	input  wire logic [FESR_NFEAT*FESR_VAL_W-1:0] feat_wr_val, // written values
	input  wire logic [FESR_ADDR_W-1:0]         s_axi_awaddr, // write address
	input  wire logic                           s_axi_awvalid,// aw valid
	output logic                                s_axi_awready,// aw ready
	input  wire logic [FESR_DATA_W-1:0]         s_axi_wdata,  // write data
	input  wire logic [3:0]                     s_axi_wstrb,  // byte strobes
	input  wire logic                           s_axi_wvalid, // w valid
	output logic                                s_axi_wready, // w ready
	output logic [1:0]                          s_axi_bresp,  // write resp
	output logic                                s_axi_bvalid, // b valid
	input  wire logic                           s_axi_bready, // b ready
	input  wire logic [FESR_ADDR_W-1:0]         s_axi_araddr, // read address
	input  wire logic                           s_axi_arvalid,// ar valid
	output logic                                s_axi_arready,// ar ready
	output logic [FESR_DATA_W-1:0]              s_axi_rdata,  // read data
	output logic [1:0]                          s_axi_rresp,  // read resp
	output logic                                s_axi_rvalid, // r valid
	input  wire logic                           s_axi_rready, // r ready
	output logic                                irq           // level irq
);

	// ----------------------------------------------------------------
	// per-feature range checks
	// ----------------------------------------------------------------
	logic [FESR_NFEAT-1:0] flag;
	logic [FESR_NFEAT-1:0] flag_prev_q;
	logic [FESR_NFEAT-1:0] flag_rise;
	logic [FESR_NFEAT-1:0] istat_q;
	logic [FESR_NFEAT-1:0] imask_q;
	logic [FESR_NFEAT-1:0] istat_clr;
	logic [FESR_NFEAT-1:0] imask_we;

	// flags come from write-time checks only; no bus path reaches them
	genvar gi;
	generate
		for (gi = 0; gi < FESR_NFEAT; gi++) begin : g_feat
			if (gi == FESR_F_WBAL && !COLOUR) begin : g_mono
				assign flag[gi] = 1'b0;
			end else begin : g_chk
				fesr_range_chk #(
					.W   (FESR_VAL_W),
					.MIN (FEAT_MIN[gi*FESR_VAL_W +: FESR_VAL_W]),
					.MAX (FEAT_MAX[gi*FESR_VAL_W +: FESR_VAL_W])
				) u_chk (
					.clk    (clk),
					.nrst   (nrst),
					.wr_stb (feat_wr_stb[gi]),
					.wr_val (feat_wr_val[gi*FESR_VAL_W +: FESR_VAL_W]),
					.err_q  (flag[gi])
				);
			end
		end
	endgenerate

	// flags only report; nothing here gates capture
	assign flag_rise = flag & ~flag_prev_q;

	// ----------------------------------------------------------------
	// word packing
	// ----------------------------------------------------------------
	// packs a flag vector into a word, doc bit n at word bit 31-n
	function automatic logic [31:0] fesr_pack(
		input logic [FESR_NFEAT-1:0] v
	);
		logic [31:0] w;
		w = FESR_WORD_RST;
		for (int i = 0; i < FESR_NFEAT; i++) begin
			w[FESR_WORD_MSB - FESR_DOC_BIT[i]] = v[i];
		end
		return w;
	endfunction

	// byte lane enable for a flag position
	function automatic logic fesr_lane(
		input logic [3:0] strb,
		input int         i
	);
		return strb[(FESR_WORD_MSB - FESR_DOC_BIT[i]) / 8];
	endfunction

	// ----------------------------------------------------------------
	// axi4-lite write channel
	// ----------------------------------------------------------------
	logic                   aw_have_q;
	logic                   w_have_q;
	logic [FESR_ADDR_W-1:0] wr_addr_q;
	logic [31:0]            wr_data_q;
	logic [3:0]             wr_strb_q;
	logic                   wr_go;
	logic                   wr_hit_istat;
	logic                   wr_hit_imask;
	logic                   wr_mapped;

	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
	assign wr_go         = aw_have_q && w_have_q && !s_axi_bvalid;

	assign wr_hit_istat = wr_addr_q[11:2] == FESR_OFS_ISTAT[11:2];
	assign wr_hit_imask = wr_addr_q[11:2] == FESR_OFS_IMASK[11:2];
	// flag words accept writes but keep nothing
	assign wr_mapped = wr_hit_istat || wr_hit_imask ||
		wr_addr_q[11:2] == FESR_OFS_UPPER[11:2] ||
		wr_addr_q[11:2] == FESR_OFS_LOWER[11:2];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aw_have_q <= 1'b0;
			wr_addr_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
			wr_addr_q <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			w_have_q  <= 1'b0;
			wr_data_q <= FESR_WORD_RST;
			wr_strb_q <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_q  <= 1'b1;
			wr_data_q <= s_axi_wdata;
			wr_strb_q <= s_axi_wstrb;
		end else if (wr_go) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= FESR_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_mapped ? FESR_RESP_OKAY : FESR_RESP_DECERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// interrupt status and mask
	// ----------------------------------------------------------------
	always_comb begin
		istat_clr = '0;
		imask_we  = '0;
		for (int i = 0; i < FESR_NFEAT; i++) begin
			istat_clr[i] = wr_go && wr_hit_istat && fesr_lane(wr_strb_q, i) &&
				wr_data_q[FESR_WORD_MSB - FESR_DOC_BIT[i]];
			imask_we[i]  = wr_go && wr_hit_imask && fesr_lane(wr_strb_q, i);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flag_prev_q <= '0;
		end else begin
			flag_prev_q <= flag;
		end
	end

	// new error sets status; a set in the clear cycle wins
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			istat_q <= '0;
		end else begin
			istat_q <= (istat_q & ~istat_clr) | flag_rise;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			imask_q <= '0;
		end else begin
			for (int i = 0; i < FESR_NFEAT; i++) begin
				if (imask_we[i]) begin
					imask_q[i] <= wr_data_q[FESR_WORD_MSB - FESR_DOC_BIT[i]];
				end
			end
		end
	end

	assign irq = |(istat_q & imask_q);

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	logic [31:0] rd_word;
	logic [1:0]  rd_resp;

	always_comb begin
		rd_word = FESR_WORD_RST;
		rd_resp = FESR_RESP_OKAY;
		case (s_axi_araddr[11:2])
			FESR_OFS_UPPER[11:2]: rd_word = fesr_pack(flag);
			FESR_OFS_LOWER[11:2]: rd_word = FESR_WORD_RST;
			FESR_OFS_ISTAT[11:2]: rd_word = fesr_pack(istat_q);
			FESR_OFS_IMASK[11:2]: rd_word = fesr_pack(imask_q);
			default:              rd_resp = FESR_RESP_DECERR;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= FESR_WORD_RST;
			s_axi_rresp  <= FESR_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_resp;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

//--- verification/fesr_checker.sv
// port-level assertions for the feature error status bank
module fesr_checker
	import fesr_pkg::*;
(
	input wire logic                   clk,           // system clock
	input wire logic                   nrst,          // async reset
	input wire logic [FESR_NFEAT-1:0]  feat_wr_stb,   // feature writes
	input wire logic [FESR_ADDR_W-1:0] s_axi_awaddr,  // write address
	input wire logic                   s_axi_awvalid, // aw valid
	input wire logic                   s_axi_awready, // aw ready
	input wire logic                   s_axi_wvalid,  // w valid
	input wire logic                   s_axi_wready,  // w ready
	input wire logic [1:0]             s_axi_bresp,   // write resp
	input wire logic                   s_axi_bvalid,  // b valid
	input wire logic                   s_axi_bready,  // b ready
	input wire logic [FESR_ADDR_W-1:0] s_axi_araddr,  // read address
	input wire logic                   s_axi_arvalid, // ar valid
	input wire logic                   s_axi_arready, // ar ready
	input wire logic [FESR_DATA_W-1:0] s_axi_rdata,   // read data
	input wire logic [1:0]             s_axi_rresp,   // read resp
	input wire logic                   s_axi_rvalid,  // r valid
	input wire logic                   s_axi_rready,  // r ready
	input wire logic                   irq            // level irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	wire ar_hs = s_axi_arvalid && s_axi_arready;
	wire wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	ar_refuse_a: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("arready not the inverse of rvalid");
	rd_latency_a: assert property (ar_hs |=> s_axi_rvalid)
		else $error("read answer late");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write resp dropped");
	aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("aw accepted during resp");
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	upper_rsvd_a: assert property (ar_hs && s_axi_araddr[11:2] == 10'h190 |=>
		(s_axi_rdata & ~32'h9188_0000) == 32'h0 && s_axi_rresp == 2'h0)
		else $error("upper reserved bit set");
	lower_zero_a: assert property (ar_hs && s_axi_araddr[11:2] == 10'h191 |=>
		s_axi_rdata == 32'h0) else $error("lower word not zero");
	// response rises one cycle after both items are held
	ro_write_a: assert property (wr_hs && s_axi_awaddr[11:3] == 9'hc8 |->
		##2 s_axi_bvalid && s_axi_bresp == 2'h0) else $error("flag write resp");
	unmapped_a: assert property (ar_hs && s_axi_araddr[11:4] != 8'h64 |=>
		s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0) else $error("no decerr");
	cover property (irq);
	cover property (s_axi_rvalid && s_axi_rresp == 2'h3);
	cover property (feat_wr_stb != 5'h0);
endmodule

bind fesr_top fesr_checker u_fesr_checker (.clk(clk), .nrst(nrst),
	.feat_wr_stb(feat_wr_stb), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

//--- verification/fesr_top_tb.sv
// self-checking bench for the feature error status bank
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
	$display("Error %0t value mismatch", $time); end end
module fesr_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, nrst, awv, wv, bready, arv, rready;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [4:0]  stb;
	logic [59:0] val;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_d;
	logic [1:0]  bresp, rresp, rs;
	int          n_errors, cmp_count;
	fesr_top u_fesr_top (.clk(clk), .nrst(nrst), .feat_wr_stb(stb),
		.feat_wr_val(val), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.irq(irq));
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	task automatic final_report();
		if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// bus and feature drivers
	// ----------------------------------------------------------------
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
		do begin
			@(posedge clk);
			if (awv && awready) awv <= 0;
			if (wv && wready) wv <= 0;
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge clk);
		araddr <= a; arv <= 1; rready <= 1;
		do begin
			@(posedge clk);
			if (arv && arready) arv <= 0;
		end while (rvalid !== 1'b1);
		rd_d = rdata; rs = rresp;
		rready <= 0;
	endtask
	task automatic fw(input int i, input logic [11:0] v);
		@(posedge clk);
		stb <= 5'h1 << i; val[i*12 +: 12] <= v;
		@(posedge clk);
		stb <= 5'h0;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		for (int a = 0; a < 4; a++) begin
			rd(12'h640 + 12'(a * 4));
			`CHK(rd_d, 32'h0)
		end
		`CHK(irq, 1'b0)
	endtask
	task automatic t_flags();
		logic [11:0] bad [5] = '{12'h100, 12'h400, 12'h000, 12'h400, 12'h010};
		logic [11:0] ok [5] = '{12'h0ff, 12'h3ff, 12'h001, 12'h000, 12'h00f};
		int pos [5] = '{31, 28, 24, 23, 19};
		for (int i = 0; i < 5; i++) begin
			fw(i, bad[i]);
			rd(12'h640);
			`CHK(rd_d, 32'h1 << pos[i])
			fw(i, ok[i]);
			rd(12'h640);
			`CHK(rd_d, 32'h0)
		end
		rd(12'h648);
		`CHK(rd_d, 32'h9188_0000)
	endtask
	task automatic t_ro();
		fw(2, 12'h000);
		wr(12'h640, 32'h0);
		`CHK(rs, 2'h0)
		wr(12'h644, 32'hffff_ffff);
		rd(12'h640);
		`CHK(rd_d, 32'h0100_0000)
		rd(12'h644);
		`CHK(rd_d, 32'h0)
		fw(2, 12'h001);
	endtask
	task automatic t_irq();
		wr(12'h648, 32'hffff_ffff);
		wr(12'h64c, 32'h8000_0000);
		fw(3, 12'h400);
		// status lands one edge after the flag; look once it has settled
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		fw(0, 12'hfff);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b1)
		wr(12'h648, 32'h8000_0000);
		@(posedge clk);
		`CHK(irq, 1'b0)
		rd(12'h648);
		`CHK(rd_d, 32'h0080_0000)
	endtask
	task automatic t_unmap();
		rd(12'h650);
		`CHK(rs, 2'h3)
		`CHK(rd_d, 32'h0)
	endtask
	initial begin
		nrst = 0; stb = 0; val = 0; awaddr = 0; araddr = 0; wdata = 0;
		awv = 0; wv = 0; bready = 0; arv = 0; rready = 0;
		n_errors = 0; cmp_count = 0;
		repeat (8) @(posedge clk);
		nrst <= 1;
		t_reset();
		t_flags();
		t_ro();
		t_irq();
		t_unmap();
		final_report();
	end
	// hang guard at 4000 clock cycles, far beyond the hundred or so cycles used
	initial begin
		#200000;
		n_errors++;
		final_report();
	end
endmodule
